// [multifunction_pin_select.sv]
// multi-function pin selector for five port-B, eight port-C and one port-D pin
// assumes an AHB-Lite master with single word transfers; pads sampled on clk
//
// Contract
// - port-B pin 4 field 9-8: gpin, keypad row 4, gpout, reserved.
// - port-B pin 3 field 7-6: gpin, keypad row 3, gpout, camera B vsync.
// - port-B pin 2 field 5-4: gpin, keypad row 2, gpout, camera B hsync.
// - port-B pin 1 field 3-2: gpin, keypad row 1, gpout, camera B clock out.
// - port-B pin 0 field 1-0: gpin, keypad row 0, gpout, camera B pixel clock.
// - port-C pins: gpin, encoder bus bit out, gpout, camera A data bit in.
// - pull-down register bits 7-0 switch the port-C pull-downs, one per pin.
// - port-D pin 3 field 7-6: gpin, audio in, gpout, camera A pixel clock.
// - pull-down register bit 11 switches the port-D pin 3 pull-down.
// - port-B pull-downs are on only in test mode.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module multifunction_pin_select
  import pin_mux_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // test mode
  input wire logic testMode,
  // gpio data
  input wire logic [4:0] gpoPortB,
  input wire logic [7:0] gpoPortC,
  input wire logic gpoPortD3,
  output logic [4:0] gpiPortB,
  output logic [7:0] gpiPortC,
  output logic gpiPortD3,
  // function engines
  output logic [4:0] keypadRowIn,
  output logic cameraBVsyncIn,
  output logic cameraBHsyncIn,
  output logic cameraBPixelClockIn,
  input wire logic cameraBMasterClockSrc,
  input wire logic [7:0] encoderPixelBusSrc,
  output logic [7:0] cameraAPixelBusIn,
  output logic pwmAudioSerialIn,
  output logic cameraAPixelClockIn,
  // pads
  input wire logic [4:0] portBPinIn,
  output logic [4:0] portBPinOut,
  output logic [4:0] portBPinOe,
  output logic [4:0] portBPullDown,
  input wire logic [7:0] portCPinsIn,
  output logic [7:0] portCPinsOut,
  output logic [7:0] portCPinsOe,
  output logic [7:0] portCPullDown,
  input wire logic portDPin3In,
  output logic portDPin3Out,
  output logic portDPin3Oe,
  output logic portDPin3PullDown
);

  if (ADDR_W < IDX_W + IDX_LSB) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  // register state
  logic [PB_SEL_W-1:0] portBSel_q, portBSel_d;
  logic [PC_SEL_W-1:0] portCSel_q, portCSel_d;
  logic [1:0] portDSel_q, portDSel_d;
  logic [7:0] pullC_q, pullC_d;
  logic pullD3_q, pullD3_d;

  // bus pipeline
  logic addrPhase;
  logic addrOk;
  logic [IDX_W-1:0] addrIdx;
  logic wrPend_q;
  logic [IDX_W-1:0] wrIdx_q;
  logic [31:0] rdValue;

  // cell input outputs gathered for routing onward; bAlt3In bits 4 and 1 go nowhere
  logic [4:0] bAlt3In;
  logic [4:0] bAlt1In;

  assign addrPhase = hsel && hready && htrans[1];
  assign addrOk = (haddr >> (IDX_W + IDX_LSB)) == '0;
  assign addrIdx = haddr[IDX_LSB +: IDX_W];

  // write lands in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrIdx_q <= '0;
    end else begin
      wrPend_q <= addrPhase && hwrite && addrOk;
      wrIdx_q <= addrIdx;
    end
  end

  // next register values include the write in its data phase
  always_comb begin
    portBSel_d = portBSel_q;
    portCSel_d = portCSel_q;
    portDSel_d = portDSel_q;
    pullC_d = pullC_q;
    pullD3_d = pullD3_q;
    if (wrPend_q) begin
      if (wrIdx_q == IDX_PORT_B) begin
        portBSel_d = hwdata[PB_SEL_W-1:0];
      end
      if (wrIdx_q == IDX_PORT_C) begin
        portCSel_d = hwdata[PC_SEL_W-1:0];
      end
      if (wrIdx_q == IDX_PORT_D) begin
        portDSel_d = hwdata[PD3_SEL_LSB +: 2];
      end
      if (wrIdx_q == IDX_PULLDOWN) begin
        pullC_d = hwdata[PD_C_LSB +: 8];
        pullD3_d = hwdata[PD_D3_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portBSel_q <= PB_SEL_RESET;
      portCSel_q <= PC_SEL_RESET;
      portDSel_q <= PD3_SEL_RESET;
    end else begin
      portBSel_q <= portBSel_d;
      portCSel_q <= portCSel_d;
      portDSel_q <= portDSel_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pullC_q <= PD_C_RESET;
      pullD3_q <= PD_D3_RESET;
    end else begin
      pullC_q <= pullC_d;
      pullD3_q <= pullD3_d;
    end
  end

  // read mux, forwarding a write still in its data phase
  always_comb begin
    rdValue = 32'h0000_0000;
    if (addrOk) begin
      unique case (addrIdx)
        IDX_PORT_B: rdValue[PB_SEL_W-1:0] = portBSel_d;
        IDX_PORT_C: rdValue[PC_SEL_W-1:0] = portCSel_d;
        IDX_PORT_D: rdValue[PD3_SEL_LSB +: 2] = portDSel_d;
        IDX_PULLDOWN: begin
          rdValue[PD_C_LSB +: 8] = pullC_d;
          rdValue[PD_D3_BIT] = pullD3_d;
        end
        IDX_LEVEL: rdValue[13:0] = {gpiPortD3, gpiPortC, gpiPortB};
        default: rdValue = 32'h0000_0000;
      endcase
    end
  end

  // zero wait state slave, always OKAY
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (addrPhase && !hwrite) begin
        hrdata <= rdValue;
      end
    end
  end

  // pull-downs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      portBPullDown <= 5'h00;
      portCPullDown <= 8'h00;
      portDPin3PullDown <= 1'b0;
    end else begin
      portBPullDown <= {5{testMode}};
      portCPullDown <= pullC_q;
      portDPin3PullDown <= pullD3_q;
    end
  end

  // port B: keypad rows on code 01, camera B lines on code 11
  for (genvar i = 0; i < 5; i++) begin : g_port_b
    pin_cell #(
      .ALT1_DRIVES(1'b0),
      .ALT3_DRIVES(i == 1)
    ) u_cell (
      .clk(clk),
      .rst_n(rst_n),
      .sel(portBSel_q[2*i +: 2]),
      .gpoBit(gpoPortB[i]),
      .alt1Out(1'b0),
      .alt3Out(cameraBMasterClockSrc),
      .padIn(portBPinIn[i]),
      .padOut(portBPinOut[i]),
      .padOe(portBPinOe[i]),
      .gpiLevel(gpiPortB[i]),
      .alt1In(bAlt1In[i]),
      .alt3In(bAlt3In[i])
    );
  end

  assign keypadRowIn = bAlt1In;
  assign cameraBVsyncIn = bAlt3In[3];
  assign cameraBHsyncIn = bAlt3In[2];
  assign cameraBPixelClockIn = bAlt3In[0];

  // port C: encoder bus out on 01, camera A data in on 11
  for (genvar i = 0; i < 8; i++) begin : g_port_c
    pin_cell #(
      .ALT1_DRIVES(1'b1),
      .ALT3_DRIVES(1'b0)
    ) u_cell (
      .clk(clk),
      .rst_n(rst_n),
      .sel(portCSel_q[2*i +: 2]),
      .gpoBit(gpoPortC[i]),
      .alt1Out(encoderPixelBusSrc[i]),
      .alt3Out(1'b0),
      .padIn(portCPinsIn[i]),
      .padOut(portCPinsOut[i]),
      .padOe(portCPinsOe[i]),
      .gpiLevel(gpiPortC[i]),
      .alt1In(),
      .alt3In(cameraAPixelBusIn[i])
    );
  end

  // port D pin 3: audio in on 01, camera A pixel clock on 11
  pin_cell #(
    .ALT1_DRIVES(1'b0),
    .ALT3_DRIVES(1'b0)
  ) u_port_d3 (
    .clk(clk),
    .rst_n(rst_n),
    .sel(portDSel_q),
    .gpoBit(gpoPortD3),
    .alt1Out(1'b0),
    .alt3Out(1'b0),
    .padIn(portDPin3In),
    .padOut(portDPin3Out),
    .padOe(portDPin3Oe),
    .gpiLevel(gpiPortD3),
    .alt1In(pwmAudioSerialIn),
    .alt3In(cameraAPixelClockIn)
  );

  // checks
  b4_keypad_a: assert property (@(posedge clk) disable iff (!rst_n)
    portBSel_q[9:8] == FN_ALT1 |=> keypadRowIn[4] == $past(portBPinIn[4]) && !portBPinOe[4])
    else $error("port B pin 4 keypad routing wrong");

  b4_reserved_a: assert property (@(posedge clk) disable iff (!rst_n)
    portBSel_q[9:8] == FN_ALT3 |=> !portBPinOe[4])
    else $error("port B pin 4 reserved code drives pad");

  b3_vsync_a: assert property (@(posedge clk) disable iff (!rst_n)
    portBSel_q[7:6] == FN_ALT3 |=> cameraBVsyncIn == $past(portBPinIn[3]) && !portBPinOe[3])
    else $error("camera B vsync routing wrong");

  b2_hsync_a: assert property (@(posedge clk) disable iff (!rst_n)
    portBSel_q[5:4] == FN_ALT3 |=> cameraBHsyncIn == $past(portBPinIn[2]) && !portBPinOe[2])
    else $error("camera B hsync routing wrong");

  b1_mclk_a: assert property (@(posedge clk) disable iff (!rst_n)
    portBSel_q[3:2] == FN_ALT3 |=>
      portBPinOe[1] && portBPinOut[1] == $past(cameraBMasterClockSrc))
    else $error("camera B master clock not driven");

  b0_gpout_a: assert property (@(posedge clk) disable iff (!rst_n)
    portBSel_q[1:0] == FN_GPOUT |=> portBPinOe[0] && portBPinOut[0] == $past(gpoPortB[0]))
    else $error("port B pin 0 gpout wrong");

  c0_encoder_a: assert property (@(posedge clk) disable iff (!rst_n)
    portCSel_q[1:0] == FN_ALT1 |=>
      portCPinsOe[0] && portCPinsOut[0] == $past(encoderPixelBusSrc[0]))
    else $error("encoder bus bit 0 not driven");

  c_field_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrPend_q && wrIdx_q == IDX_PORT_C ##1 1'b1 |->
      portCSel_q == $past(hwdata[PC_SEL_W-1:0]))
    else $error("port C select write lost");

  c_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrPend_q && wrIdx_q == IDX_PULLDOWN |-> ##2 portCPullDown == $past(hwdata[7:0], 2))
    else $error("port C pull-down not applied");

  d3_audio_a: assert property (@(posedge clk) disable iff (!rst_n)
    portDSel_q == FN_ALT1 |=> pwmAudioSerialIn == $past(portDPin3In) && !portDPin3Oe)
    else $error("audio input routing wrong");

  d3_pull_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrPend_q && wrIdx_q == IDX_PULLDOWN |-> ##2 portDPin3PullDown == $past(hwdata[11], 2))
    else $error("port D pin 3 pull-down not applied");

  b_pull_test_a: assert property (@(posedge clk) disable iff (!rst_n)
    !testMode [*2] |-> portBPullDown == 5'h00)
    else $error("port B pull-down on outside test mode");

  c_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    portCSel_q == PC_SEL_RESET |=> portCPinsOe == 8'h00)
    else $error("port C pad driven as gpin");

endmodule

// [pin_mux_pkg.sv]
// constants for the multi-function pin selector
// assumes word-indexed registers on a 32-bit bus, byte address = index * 4
package pin_mux_pkg;

  // register indices; the byte address is four times the index
  localparam logic [11:0] IDX_PULLDOWN = 12'h464;
  localparam logic [11:0] IDX_PORT_B = 12'hc06;
  localparam logic [11:0] IDX_PORT_C = 12'hc0a;
  localparam logic [11:0] IDX_PORT_D = 12'hc0e;
  localparam logic [11:0] IDX_LEVEL = 12'hc10;

  // lowest address bit that the word index starts at, and index width
  localparam int IDX_LSB = 2;
  localparam int IDX_W = 12;

  // field positions
  localparam int PB_SEL_W = 10;
  localparam int PC_SEL_W = 16;
  localparam int PD3_SEL_LSB = 6;
  localparam int PD_C_LSB = 0;
  localparam int PD_D3_BIT = 11;

  // values after reset
  localparam logic [PB_SEL_W-1:0] PB_SEL_RESET = 10'h000;
  localparam logic [PC_SEL_W-1:0] PC_SEL_RESET = 16'h0000;
  localparam logic [1:0] PD3_SEL_RESET = 2'h0;
  localparam logic [7:0] PD_C_RESET = 8'h00;
  localparam logic PD_D3_RESET = 1'b0;

  // selector codes of every two-bit pin field
  typedef enum logic [1:0] {
    FN_GPIN = 2'b00,
    FN_ALT1 = 2'b01,
    FN_GPOUT = 2'b10,
    FN_ALT3 = 2'b11
  } pin_func_t;

endpackage

// [pin_cell.sv]
// one multi-function pad slice: output steering and input routing
// assumes the pad input is synchronous to clk
`timescale 1ns/1ps
module pin_cell
  import pin_mux_pkg::*;
#(
  parameter bit ALT1_DRIVES = 1'b0,
  parameter bit ALT3_DRIVES = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // selection and output sources
  input wire logic [1:0] sel,
  input wire logic gpoBit,
  input wire logic alt1Out,
  input wire logic alt3Out,
  // pad
  input wire logic padIn,
  output logic padOut,
  output logic padOe,
  // routed inputs
  output logic gpiLevel,
  output logic alt1In,
  output logic alt3In
);

  logic drive;
  logic outVal;

  always_comb begin
    drive = 1'b0;
    outVal = 1'b0;
    unique case (pin_func_t'(sel))
      FN_GPIN: begin
        drive = 1'b0;
      end
      FN_ALT1: begin
        drive = ALT1_DRIVES;
        outVal = ALT1_DRIVES ? alt1Out : 1'b0;
      end
      FN_GPOUT: begin
        drive = 1'b1;
        outVal = gpoBit;
      end
      FN_ALT3: begin
        drive = ALT3_DRIVES;
        outVal = ALT3_DRIVES ? alt3Out : 1'b0;
      end
    endcase
  end

  // driver released unless gpo or a driving function is chosen
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padOe <= 1'b0;
      padOut <= 1'b0;
    end else begin
      padOe <= drive;
      padOut <= outVal;
    end
  end

  // alternate input functions see the pad only while selected; gpiLevel always does
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpiLevel <= 1'b0;
      alt1In <= 1'b0;
      alt3In <= 1'b0;
    end else begin
      gpiLevel <= padIn;
      alt1In <= (sel == FN_ALT1 && !ALT1_DRIVES) ? padIn : 1'b0;
      alt3In <= (sel == FN_ALT3 && !ALT3_DRIVES) ? padIn : 1'b0;
    end
  end

endmodule

// [pad_model.sv]
// pad world model: outside drivers, pull-downs and a floating level per pin
// assumes the bench sets extEn/extVal and the design drives out/oe/pullDown
`timescale 1ns/1ps
module pad_model #(
  parameter int N = 1
) (
  // clock
  input wire logic clk,
  // design side
  input wire logic [N-1:0] pinOut,
  input wire logic [N-1:0] pinOe,
  input wire logic [N-1:0] pullDown,
  // outside drivers
  input wire logic [N-1:0] extEn,
  input wire logic [N-1:0] extVal,
  // resolved level
  output logic [N-1:0] level
);
  logic [N-1:0] floatQ = '0;
  // an undriven pin without pull-down wanders each cycle
  always @(posedge clk) begin
    floatQ <= ~floatQ;
  end
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (pinOe[i]) level[i] = pinOut[i];
      else if (extEn[i]) level[i] = extVal[i];
      else if (pullDown[i]) level[i] = 1'b0;
      else level[i] = floatQ[i];
    end
  end
endmodule

// [multifunction_pin_select_tb.sv]
// self-checking bench for the multi-function pin selector
// assumes one AHB-Lite slave, so hready is the design's own hreadyout
`timescale 1ns/1ps
module multifunction_pin_select_tb;
  import pin_mux_pkg::*;
  localparam logic [15:0] A_PD = 16'({IDX_PULLDOWN, 2'b00});
  localparam logic [15:0] A_B = 16'({IDX_PORT_B, 2'b00});
  localparam logic [15:0] A_C = 16'({IDX_PORT_C, 2'b00});
  localparam logic [15:0] A_D = 16'({IDX_PORT_D, 2'b00});
  localparam logic [15:0] A_L = 16'({IDX_LEVEL, 2'b00});
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic testMode = 1'b0;
  logic [4:0] gpoB = 5'h0a;
  logic [7:0] gpoC = 8'h3c;
  logic gpoD = 1'b0;
  logic camBClk = 1'b1;
  logic [7:0] encSrc = 8'hc3;
  logic [4:0] bExtEn = 5'h1f;
  logic [4:0] bExtVal = 5'h1d;
  logic [7:0] cExtEn = 8'hff;
  logic [7:0] cExtVal = 8'h5a;
  logic dExtEn = 1'b1;
  logic dExtVal = 1'b1;
  logic [4:0] gpiB, keyRow, bOut, bOe, bPd, bLvl;
  logic [7:0] gpiC, camABus, cOut, cOe, cPd, cLvl;
  logic gpiD, audio, camAClk, dOut, dOe, dPd, dLvl;
  logic vsB, hsB, pclkB;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  always #2 clk = ~clk;

  multifunction_pin_select u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .testMode(testMode),
    .gpoPortB(gpoB), .gpoPortC(gpoC), .gpoPortD3(gpoD), .gpiPortB(gpiB), .gpiPortC(gpiC),
    .gpiPortD3(gpiD), .keypadRowIn(keyRow), .cameraBVsyncIn(vsB), .cameraBHsyncIn(hsB),
    .cameraBPixelClockIn(pclkB), .cameraBMasterClockSrc(camBClk),
    .encoderPixelBusSrc(encSrc), .cameraAPixelBusIn(camABus), .pwmAudioSerialIn(audio),
    .cameraAPixelClockIn(camAClk), .portBPinIn(bLvl), .portBPinOut(bOut), .portBPinOe(bOe),
    .portBPullDown(bPd), .portCPinsIn(cLvl), .portCPinsOut(cOut), .portCPinsOe(cOe),
    .portCPullDown(cPd), .portDPin3In(dLvl), .portDPin3Out(dOut), .portDPin3Oe(dOe),
    .portDPin3PullDown(dPd));
  pad_model #(.N(5)) uPadB (.clk(clk), .pinOut(bOut), .pinOe(bOe), .pullDown(bPd),
    .extEn(bExtEn), .extVal(bExtVal), .level(bLvl));
  pad_model #(.N(8)) uPadC (.clk(clk), .pinOut(cOut), .pinOe(cOe), .pullDown(cPd),
    .extEn(cExtEn), .extVal(cExtVal), .level(cLvl));
  pad_model #(.N(1)) uPadD (.clk(clk), .pinOut(dOut), .pinOe(dOe), .pullDown(dPd),
    .extEn(dExtEn), .extVal(dExtVal), .level(dLvl));

  task stop_test;
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask

  task automatic rdChk(input string name, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(name, r, exp);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic resetVals;
    rdChk("pd reg", A_PD, 32'h0);
    rdChk("b sel", A_B, 32'h0);
    rdChk("c sel", A_C, 32'h0);
    rdChk("d sel", A_D, 32'h0);
    rdChk("level", A_L, {18'h0, dExtVal, cExtVal, bExtVal});
    chk("bus resp", {hreadyout, hresp}, 32'h2);
    chk("oe after reset", {bOe, cOe, dOe}, 32'h0);
    chk("gpi after reset", {gpiB, gpiC, gpiD}, {5'h1d, 8'h5a, 1'b1});
  endtask

  task automatic portB;
    logic [4:0] oe, out;
    for (int k = 0; k < 4; k++) begin
      wr(A_B, {22'h0, {5{2'(k)}}});
      rdChk("b sel", A_B, {22'h0, {5{2'(k)}}});
      settle();
      oe = (k == 2) ? 5'h1f : (k == 3) ? 5'h02 : 5'h00;
      out = (k == 2) ? gpoB : (k == 3) ? 5'h02 : 5'h00;
      chk("b oe", bOe, oe);
      chk("b out", bOut, out);
      chk("b gpi", gpiB, (5'h1d & ~oe) | (out & oe));
      chk("keypad", keyRow, (k == 1) ? 5'h1d : 5'h00);
      chk("cam b", {vsB, hsB, pclkB}, (k == 3) ? 3'h7 : 3'h0);
      if (k == 3) begin
        @(posedge clk);
        camBClk <= 1'b0;
        settle();
        chk("b mclk low", {bOe, bOut}, {5'h02, 5'h00});
      end
    end
  endtask

  task automatic portC;
    logic [15:0] sel;
    logic [7:0] oe, out, cam;
    logic [1:0] code;
    for (int k = 0; k < 4; k++) begin
      for (int n = 0; n < 8; n++) begin
        code = 2'((n + k) % 4);
        sel[2*n +: 2] = code;
        oe[n] = (code == 2'h1) || (code == 2'h2);
        out[n] = (code == 2'h1) ? encSrc[n] : (code == 2'h2) ? gpoC[n] : 1'b0;
        cam[n] = (code == 2'h3) ? cExtVal[n] : 1'b0;
      end
      wr(A_C, {16'h0, sel});
      rdChk("c sel", A_C, {16'h0, sel});
      settle();
      chk("c oe", cOe, oe);
      chk("c out", cOut, out);
      chk("cam a bus", camABus, cam);
      chk("c gpi", gpiC, (8'h5a & ~oe) | (out & oe));
    end
  endtask

  task automatic portD;
    for (int k = 0; k < 4; k++) begin
      wr(A_D, 32'(k) << 6);
      rdChk("d sel", A_D, 32'(k) << 6);
      settle();
      chk("d oe out", {dOe, dOut}, {k == 2, 1'b0});
      chk("d engines", {audio, camAClk}, {k == 1, k == 3});
      chk("d gpi", gpiD, k != 2);
      if (k == 2) begin
        @(posedge clk);
        gpoD <= 1'b1;
        settle();
        chk("d gpout high", {dOe, dOut}, 2'h3);
        @(posedge clk);
        gpoD <= 1'b0;
      end
    end
  endtask

  task automatic pullDowns;
    wr(A_PD, 32'hffff);
    rdChk("pd reg", A_PD, 32'h08ff);
    settle();
    chk("pd on", {cPd, dPd}, 9'h1ff);
    @(posedge clk);
    dExtEn <= 1'b0;
    settle();
    chk("d pulled low", gpiD, 1'b0);
    @(posedge clk);
    dExtEn <= 1'b1;
    wr(A_PD, 32'h00a5);
    settle();
    chk("pd mix", {cPd, dPd}, {8'ha5, 1'b0});
    rdChk("unmapped", 16'h3000, 32'h0);
  endtask

  task automatic testPulls;
    chk("b pd off", bPd, 5'h00);
    @(posedge clk);
    testMode <= 1'b1;
    settle();
    chk("b pd test", bPd, 5'h1f);
    @(posedge clk);
    testMode <= 1'b0;
    settle();
    chk("b pd normal", bPd, 5'h00);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    resetVals();
    portB();
    portC();
    portD();
    pullDowns();
    testPulls();
    stop_test();
  end
endmodule
